/* design/tta_pkg.sv */
// Package: register map, field layouts, reset values and carriers of the trigger term block
package tta_pkg;
  // Byte offsets of the APB registers
  localparam logic [7:0] TTA_CTRL = 8'h00; // Mode bit
  localparam logic [7:0] TTA_OWNER = 8'h04; // Term ownership, one bit per pattern, bounds and timer term
  localparam logic [7:0] TTA_CMD = 8'h08; // Preset commands, write only
  localparam logic [7:0] TTA_ARM = 8'h0c; // Arming configuration
  localparam logic [7:0] TTA_COMB0 = 8'h10; // Combination for machine 0
  localparam logic [7:0] TTA_COMB1 = 8'h14; // Combination for machine 1
  localparam logic [7:0] TTA_STAT = 8'h18; // Live status, read only
  localparam logic [7:0] TTA_INV = 8'h1c; // Inversion of pattern and bounds terms
  localparam logic [7:0] TTA_PAT = 8'h20; // Ten pattern words, value low, care high
  localparam logic [7:0] TTA_RNG = 8'h48; // Two bounds words, lower low, upper high
  localparam logic [7:0] TTA_EDGE = 8'h50; // Two transition words, rise low, fall high
  localparam logic [7:0] TTA_TPER = 8'h58; // Two timer periods in cycles
  localparam logic [7:0] TTA_TLVL = 8'h60; // Twelve per-level timer control words
  localparam logic [7:0] TTA_END = 8'h90; // First offset past the map
  // Counts
  localparam int TTA_NPAT = 10;
  localparam int TTA_NLVL = 12;
  // Field positions in the arming word
  localparam int ARM_SRC = 0;
  localparam int ARM_PIN = 2;
  localparam int ARM_OUT = 4;
  localparam int ARM_OEN = 6;
  localparam int ARM_SCP = 7;
  localparam int ARM_LVL = 8;
  localparam int ARM_XAN = 16;
  // Arm sources
  localparam logic [1:0] SRC_RUN = 2'h0;
  localparam logic [1:0] SRC_GROUP = 2'h1;
  localparam logic [1:0] SRC_PORT = 2'h2;
  // Preset command codes in bits 5:4 of the command word
  localparam logic [1:0] CMD_CLEAR = 2'h1;
  localparam logic [1:0] CMD_SET = 2'h2;
  localparam logic [1:0] CMD_RESET = 2'h3;
  // Timer commands, three bits each
  localparam logic [2:0] TC_OFF = 3'h0;
  localparam logic [2:0] TC_START = 3'h1;
  localparam logic [2:0] TC_PAUSE = 3'h2;
  localparam logic [2:0] TC_CONT = 3'h3;
  localparam logic [2:0] TC_STOP = 3'h4;
  // Shortest timer period
  localparam int CLK_PS = 8000;
  localparam int TMR_MIN_NS = 400;
  localparam logic [23:0] TMR_MIN_CYC = 24'((TMR_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS);
  // Term vector seen by a machine: 9:0 pattern, 11:10 bounds, 13:12 edges, 15:14 timers, 16 arm
  typedef logic [16:0] tta_terms_t;
  // Sequencer handshake for one machine
  typedef struct packed {
    logic [3:0] level;
    logic enter;
    logic prim_hit;
    logic sec_hit;
    logic trig;
  } tta_seq_s;
  // Whole module state
  typedef struct packed {
    logic timing;
    logic [13:0] owner;
    logic [9:0][15:0] pval;
    logic [9:0][15:0] pcare;
    logic [9:0] pinv;
    logic [1:0][15:0] rlo;
    logic [1:0][15:0] rhi;
    logic [1:0] rout;
    logic [1:0][15:0] erise;
    logic [1:0][15:0] efall;
    logic [1:0][23:0] tper;
    logic [1:0][23:0] tcnt;
    logic [1:0] trun;
    logic [1:0] texp;
    logic [11:0][5:0] tlvl;
    logic [1:0][15:0] csel;
    logic [1:0] cor;
    logic [1:0] cinv;
    logic [1:0] asrc;
    logic [1:0] pin_tgt;
    logic [1:0] aout_src;
    logic aout_en;
    logic scope_by_an;
    logic [1:0][3:0] alvl;
    logic [1:0] an_by_an;
    logic [1:0] armed;
    logic scope_arm;
    logic arm_out;
    logic [15:0] prev;
    logic [31:0] rdata;
    logic slverr;
  } tta_state_s;
  localparam tta_state_s TTA_RST = '{
    rhi: {2{16'hffff}},
    tper: {2{TMR_MIN_CYC}},
    default: '0
  };
endpackage

/* design/tta_trigger_terms.sv */
// Trigger resource terms, timers, combination and arming for two analyzer machines
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1: Ten pattern terms, per-bit care, invertible
// R2: Two bounds terms, both bounds inclusive
// R3: Bounds term usable in or out of range
// R4: Numeric compare on one label, no clock bits
// R5: Two transition terms, rising falling or any
// R6: Several selected channels are ORed together
// R7: Transition terms only in timing mode
// R8: Two global timers, first level cannot control
// R9: Start counts on level entry, true at expiry
// R10: Paused timer holds until continued
// R11: Level timer control defaults to off
// R12: Expiry or stop clears the count
// R13: Each term owned by one machine only
// R14: Clear widens terms, timers 400 ns minimum
// R15: Set and reset load pattern ones or zeros
// R16: Chain of terms forms one combined qualifier
// R17: Arm-in makes arm term true at level
// R18: Arm term evaluated like any other term
// R19: Arm source run, group run or port
// R20: Port in arms scope or analyzers; one out
// R21: Scope armed by the arm-out analyzer
// R22: Default is independent running, no arming
// R23: Primary branch wins when both true
// R24: Terms evaluated each sample, same cycle
module tta_trigger_terms
  import tta_pkg::*;
(
  input wire logic pclk, // APB and sample clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] sample, // Label value of one pod pair, clock bits excluded
  input wire logic run_start, // Pulse at start of a run
  input wire logic arm_in, // External arm input pulse
  input wire logic scope_trig, // Oscilloscope trigger pulse
  input wire tta_seq_s seq0, // Sequencer of machine 0
  input wire tta_seq_s seq1, // Sequencer of machine 1
  output tta_terms_t terms0, // Terms of machine 0
  output tta_terms_t terms1, // Terms of machine 1
  output logic [1:0] comb_hit, // Combined qualifier per machine
  output logic [1:0] take_prim, // Primary branch taken
  output logic [1:0] take_sec, // Secondary branch taken
  output logic scope_arm, // Arms the oscilloscope
  output logic arm_out // External arm output
);
  tta_state_s st; // Registered state
  tta_state_s next_st; // Next state
  logic [9:0] pat_hit; // Raw pattern results
  logic [1:0] rng_hit; // Raw bounds results
  logic [1:0] edg_hit; // Raw transition results
  tta_terms_t raw; // All terms before ownership split
  logic [3:0] widx; // Word index inside a table
  logic [3:0] ridx; // Word index for reads
  logic wr; // Write access phase
  logic rd_setup; // Setup phase of any access
  logic mapped; // Address hits the map

  // Per-term comparators; purely combinational so results reach the sequencer this cycle
  genvar g;
  generate
    for (g = 0; g < TTA_NPAT; g++) begin : g_pat
      assign pat_hit[g] = st.pinv[g] ^ (((sample ^ st.pval[g]) & st.pcare[g]) == 16'h0000); // R1 R24
    end
    for (g = 0; g < 2; g++) begin : g_rng
      // Unsigned compare on the label value; both ends count as a match
      assign rng_hit[g] = st.rout[g] ^ ((sample >= st.rlo[g]) && (sample <= st.rhi[g])); // R2 R3 R4
      // Any selected channel edge fires the term; mode gate keeps state mode clean
      assign edg_hit[g] = st.timing
        && (|((sample & ~st.prev & st.erise[g]) | (~sample & st.prev & st.efall[g]))); // R5 R6 R7
    end
  endgenerate

  // Ownership split: edges stay with machine 0, arm term is each machine's own
  always_comb begin
    raw = {1'b0, st.texp, edg_hit, rng_hit, pat_hit};
    terms0 = raw & {1'b0, 2'b11, 14'h0000} | raw & {3'b000, ~st.owner}; // R13
    terms1 = raw & {3'b000, st.owner}; // R13
    terms0[15:14] = st.texp & ~st.owner[13:12]; // R13
    terms1[15:14] = st.texp & st.owner[13:12]; // R13
    terms0[13:12] = edg_hit; // R13
    terms1[13:12] = 2'b00;
    terms0[16] = st.armed[0] && (seq0.level == st.alvl[0]); // R17 R18
    terms1[16] = st.armed[1] && (seq1.level == st.alvl[1]); // R17 R18
  end

  // Combined qualifier: selected terms chained by AND or OR, optional inversion
  always_comb begin
    comb_hit[0] = st.cinv[0] ^ (st.cor[0] ? |(terms0[15:0] & st.csel[0])
                  : &(terms0[15:0] | ~st.csel[0])); // R16
    comb_hit[1] = st.cinv[1] ^ (st.cor[1] ? |(terms1[15:0] & st.csel[1])
                  : &(terms1[15:0] | ~st.csel[1])); // R16
  end

  // Branch choice; the primary branch has priority on a tie
  assign take_prim = {seq1.prim_hit, seq0.prim_hit}; // R23
  assign take_sec = {seq1.sec_hit & ~seq1.prim_hit, seq0.sec_hit & ~seq0.prim_hit}; // R23

  // APB decode; zero wait states, read data latched in the setup cycle
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr < TTA_END);
  assign widx = 4'((paddr - TTA_PAT) >> 2);
  assign ridx = widx;
  assign pready = 1'b1;
  assign prdata = st.rdata;
  assign pslverr = st.slverr;
  assign scope_arm = st.scope_arm;
  assign arm_out = st.arm_out;

  // Next-state logic: registers, commands, timers and arming
  always_comb begin
    logic [2:0] cmd;
    logic m;
    logic [1:0] tgt;
    logic srcan;
    next_st = st;
    cmd = TC_OFF;
    m = 1'b0;
    tgt = 2'b00;
    srcan = 1'b0;
    next_st.prev = sample;
    // Register writes at the access edge
    if (wr && mapped) begin
      if (paddr == TTA_CTRL) begin
        next_st.timing = pwdata[0];
      end else if (paddr == TTA_OWNER) begin
        next_st.owner = pwdata[13:0];
      end else if (paddr == TTA_CMD) begin
        // Presets; set and reset touch pattern terms only
        if (pwdata[3:0] < 4'd10) begin
          case (pwdata[5:4])
            CMD_CLEAR: next_st.pcare[pwdata[3:0]] = 16'h0000; // R14
            CMD_SET: begin
              next_st.pval[pwdata[3:0]] = 16'hffff; // R15
              next_st.pcare[pwdata[3:0]] = 16'hffff; // R15
            end
            CMD_RESET: begin
              next_st.pval[pwdata[3:0]] = 16'h0000; // R15
              next_st.pcare[pwdata[3:0]] = 16'hffff; // R15
            end
            default: ;
          endcase
        end else if (pwdata[5:4] == CMD_CLEAR) begin
          // Widest meaning for bounds, timers and edges
          case (pwdata[3:0])
            4'd10, 4'd11: begin
              next_st.rlo[pwdata[0]] = 16'h0000; // R14
              next_st.rhi[pwdata[0]] = 16'hffff; // R14
            end
            4'd12, 4'd13: next_st.tper[pwdata[0]] = TMR_MIN_CYC; // R14
            default: begin
              next_st.erise[pwdata[0]] = 16'h0000; // R14
              next_st.efall[pwdata[0]] = 16'h0000; // R14
            end
          endcase
        end
      end else if (paddr == TTA_ARM) begin
        next_st.asrc = pwdata[ARM_SRC+:2]; // R19
        next_st.pin_tgt = pwdata[ARM_PIN+:2]; // R20
        next_st.aout_src = pwdata[ARM_OUT+:2]; // R20
        next_st.aout_en = pwdata[ARM_OEN];
        next_st.scope_by_an = pwdata[ARM_SCP];
        next_st.alvl = pwdata[ARM_LVL+:8];
        next_st.an_by_an = pwdata[ARM_XAN+:2];
      end else if (paddr == TTA_COMB0 || paddr == TTA_COMB1) begin
        next_st.csel[paddr[2]] = pwdata[15:0];
        next_st.cor[paddr[2]] = pwdata[16];
        next_st.cinv[paddr[2]] = pwdata[17];
      end else if (paddr == TTA_INV) begin
        next_st.pinv = pwdata[9:0];
        next_st.rout = pwdata[11:10];
      end else if (paddr >= TTA_PAT && paddr < TTA_RNG) begin
        next_st.pval[widx] = pwdata[15:0];
        next_st.pcare[widx] = pwdata[31:16];
      end else if (paddr >= TTA_RNG && paddr < TTA_EDGE) begin
        next_st.rlo[paddr[2]] = pwdata[15:0];
        next_st.rhi[paddr[2]] = pwdata[31:16];
      end else if (paddr >= TTA_EDGE && paddr < TTA_TPER) begin
        next_st.erise[paddr[2]] = pwdata[15:0];
        next_st.efall[paddr[2]] = pwdata[31:16];
      end else if (paddr >= TTA_TPER && paddr < TTA_TLVL) begin
        // Periods below the floor are raised to it
        next_st.tper[paddr[2]] = (pwdata[23:0] < TMR_MIN_CYC) ? TMR_MIN_CYC : pwdata[23:0]; // R14
      end else if (paddr >= TTA_TLVL) begin
        next_st.tlvl[4'((paddr - TTA_TLVL) >> 2)] = pwdata[5:0]; // R11
      end
    end
    // Global timers, driven by the owning machine's level entries
    for (int t = 0; t < 2; t++) begin
      m = st.owner[12+t];
      cmd = TC_OFF;
      if (m ? seq1.enter : seq0.enter) begin
        // The first level never controls a timer
        if ((m ? seq1.level : seq0.level) != 4'h0) begin
          cmd = st.tlvl[m ? seq1.level : seq0.level][3*t+:3]; // R8
        end
      end
      if (st.trun[t]) begin
        if (st.tcnt[t] + 24'h000001 >= st.tper[t]) begin
          next_st.texp[t] = 1'b1; // R9
          next_st.tcnt[t] = 24'h000000; // R12
          next_st.trun[t] = 1'b0;
        end else begin
          next_st.tcnt[t] = st.tcnt[t] + 24'h000001;
        end
      end
      case (cmd)
        TC_START: begin
          next_st.tcnt[t] = 24'h000000; // R9
          next_st.trun[t] = 1'b1;
          next_st.texp[t] = 1'b0;
        end
        TC_PAUSE: begin
          next_st.tcnt[t] = st.tcnt[t]; // R10
          next_st.trun[t] = 1'b0; // R10
          next_st.texp[t] = st.texp[t];
        end
        TC_CONT: next_st.trun[t] = !st.texp[t]; // R10
        TC_STOP: begin
          next_st.tcnt[t] = 24'h000000; // R12
          next_st.trun[t] = 1'b0;
          next_st.texp[t] = 1'b0;
        end
        default: ; // R11
      endcase
    end
    // Analyzer arming; a new run clears, any arming event in the same cycle wins
    for (int a = 0; a < 2; a++) begin
      if (run_start) begin
        next_st.armed[a] = 1'b0;
      end
      if (!st.an_by_an[a]) begin
        if (run_start && st.asrc != SRC_PORT) begin
          next_st.armed[a] = 1'b1; // R19
        end
        if (arm_in && st.asrc == SRC_PORT && st.pin_tgt[1]) begin
          next_st.armed[a] = 1'b1; // R17 R20
        end
      end else if (a == 0 ? seq1.trig : seq0.trig) begin
        next_st.armed[a] = 1'b1; // R19
      end
    end
    // Scope arming; an analyzer that drives arm-out must also be the one arming the scope
    srcan = (st.aout_en && st.aout_src != 2'h2) ? st.aout_src[0] : 1'b0; // R21
    next_st.scope_arm = 1'b0;
    if (st.scope_by_an) begin
      next_st.scope_arm = srcan ? seq1.trig : seq0.trig; // R21
    end else if (st.asrc == SRC_PORT && st.pin_tgt[0]) begin
      next_st.scope_arm = arm_in; // R20
    end else if (st.asrc != SRC_PORT) begin
      next_st.scope_arm = run_start; // R19
    end
    // Arm-out comes from one machine or the scope trigger, off by default
    tgt = st.aout_src;
    next_st.arm_out = st.aout_en && (tgt == 2'h0 ? seq0.trig : tgt == 2'h1 ? seq1.trig
                      : scope_trig); // R20 R22
    // Read data latched in the setup phase
    next_st.slverr = rd_setup && !mapped;
    next_st.rdata = 32'h00000000;
    if (rd_setup && mapped && !pwrite) begin
      if (paddr == TTA_CTRL) next_st.rdata = {31'h0, st.timing};
      else if (paddr == TTA_OWNER) next_st.rdata = {18'h0, st.owner};
      else if (paddr == TTA_ARM) next_st.rdata = {14'h0, st.an_by_an, st.alvl, st.scope_by_an,
        st.aout_en, st.aout_src, st.pin_tgt, st.asrc};
      else if (paddr == TTA_COMB0 || paddr == TTA_COMB1) next_st.rdata = {14'h0,
        st.cinv[paddr[2]], st.cor[paddr[2]], st.csel[paddr[2]]};
      else if (paddr == TTA_STAT) next_st.rdata = {st.armed, st.trun, 10'h0, terms1[16],
        terms0};
      else if (paddr == TTA_INV) next_st.rdata = {20'h0, st.rout, st.pinv};
      else if (paddr >= TTA_PAT && paddr < TTA_RNG) next_st.rdata = {st.pcare[ridx],
        st.pval[ridx]};
      else if (paddr >= TTA_RNG && paddr < TTA_EDGE) next_st.rdata = {st.rhi[paddr[2]],
        st.rlo[paddr[2]]};
      else if (paddr >= TTA_EDGE && paddr < TTA_TPER) next_st.rdata = {st.efall[paddr[2]],
        st.erise[paddr[2]]};
      else if (paddr >= TTA_TPER && paddr < TTA_TLVL) next_st.rdata = {8'h0, st.tper[paddr[2]]};
      else if (paddr >= TTA_TLVL) next_st.rdata = {26'h0,
        st.tlvl[4'((paddr - TTA_TLVL) >> 2)]};
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= TTA_RST; // R11 R22
    end else begin
      st <= next_st;
    end
  end

  // Checks kept beside the logic
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_start0;
    seq0.enter && seq0.level != 4'h0 && !st.owner[12] && st.tlvl[seq0.level][2:0] == TC_START;
  endsequence
  sequence s_pause0;
    seq0.enter && seq0.level != 4'h0 && !st.owner[12] && st.tlvl[seq0.level][2:0] == TC_PAUSE;
  endsequence
  pat_match_a: assert property (!st.pinv[0] && (sample & st.pcare[0]) == (st.pval[0]
    & st.pcare[0]) |-> pat_hit[0]) else $error("pattern term missed a match"); // R1
  bounds_incl_a: assert property (!st.rout[0] && sample == st.rhi[0] && sample >= st.rlo[0]
    |-> rng_hit[0]) else $error("upper bound not inclusive"); // R2
  bounds_out_a: assert property (st.rout[1] && sample < st.rlo[1] |-> rng_hit[1])
    else $error("out of range term wrong"); // R3
  edge_mode_a: assert property (!st.timing |-> terms0[13:12] == 2'b00)
    else $error("edge term active in state mode"); // R7
  owner_excl_a: assert property ((terms0[15:0] & terms1[15:0]) == 16'h0000)
    else $error("term seen by both machines"); // R13
  timer_start_a: assert property (s_start0 ##1 !seq0.enter [*2] |-> st.trun[0]
    && st.tcnt[0] == 24'h000001) else $error("timer did not start counting"); // R9
  timer_pause_a: assert property (s_pause0 ##1 !seq0.enter [*3] |-> $stable(st.tcnt[0])
    && $stable(st.texp[0])) else $error("paused timer moved"); // R10
  timer_clear_a: assert property ($rose(st.texp[0]) |-> st.tcnt[0] == 24'h000000)
    else $error("count not cleared at expiry"); // R12
  prim_wins_a: assert property (seq0.prim_hit && seq0.sec_hit |-> take_prim[0] && !take_sec[0])
    else $error("secondary branch beat primary"); // R23
  arm_level_a: assert property (arm_in && st.asrc == SRC_PORT && st.pin_tgt[1]
    && !st.an_by_an[0] && !run_start ##1 seq0.level == st.alvl[0] |-> terms0[16])
    else $error("arm term not raised at level"); // R17
  arm_out_off_a: assert property (!st.aout_en |=> !arm_out)
    else $error("arm out without selection"); // R22
endmodule
`default_nettype wire

/* tb/test_tta_trigger_terms.sv */
// Self-checking bench for the trigger term and arming block
`timescale 1ns/1ps
`default_nettype none
module test_tta_trigger_terms;
  import tta_pkg::*;
  logic pclk = 1'b0; // Sample and bus clock
  logic presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q; // Bus data and last read word
  logic [15:0] sample;
  logic arm_in, run_start, scope_trig, scope_arm, arm_out;
  tta_seq_s seq0, seq1; // Sequencer stand-ins
  tta_terms_t terms0, terms1;
  logic [1:0] comb_hit, take_prim, take_sec;
  int miscompares, checked, n;
  logic [15:0] rv [4] = '{16'h000f, 16'h0010, 16'h0020, 16'h0021}; // Bound edge cases
  logic re [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  // 125 MHz clock
  always #4 pclk = ~pclk;

  tta_trigger_terms DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample(sample), .run_start(run_start), .arm_in(arm_in),
    .scope_trig(scope_trig), .seq0(seq0), .seq1(seq1), .terms0(terms0), .terms1(terms1),
    .comb_hit(comb_hit), .take_prim(take_prim), .take_sec(take_sec),
    .scope_arm(scope_arm), .arm_out(arm_out));
  tta_target_model u_target (.pclk(pclk), .sample(sample), .arm_in(arm_in));

  // Word compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Single-bit compare
  task chkb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  // One APB transfer; the wait on pready is bounded so a dead slave cannot hang the run
  // Setup starts just after an edge, which also leaves an idle cycle between transfers
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      end_sim();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // Machine 0 enters a sequence level
  task enter(input logic [3:0] l);
    seq0.level <= l;
    seq0.enter <= 1'b1;
    @(posedge pclk);
    seq0.enter <= 1'b0;
  endtask
  // Cycles until timer 0 reports expiry, capped at 200; looked at on falling edges where settled
  task wait_tmr();
    n = 0;
    @(negedge pclk);
    while (terms0[14] !== 1'b1 && n < 200) begin
      @(negedge pclk);
      n++;
    end
    if (n >= 200) begin
      miscompares++;
      end_sim();
    end
    @(posedge pclk);
  endtask
  // Single exit: counts, verdict, stop
  task end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, run_start, scope_trig} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seq0 = '0;
    seq1 = '0;
    miscompares = 0;
    checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state: independent running, widest terms, timer controls off
    rd(TTA_ARM, 32'h0);
    rd(TTA_RNG, 32'hffff0000);
    rd(TTA_TPER, {8'h00, TMR_MIN_CYC});
    rd(TTA_TLVL + 8'h04, 32'h0);
    #1 chkb(terms0[0], 1'b1);
    apb(1'b0, TTA_END, 32'h0);
    chkb(err, 1'b1);
    // Pattern with don't-care high byte, then inverted sense
    wr(TTA_PAT, 32'h00ff0034);
    u_target.put(16'hab34);
    #1 chkb(terms0[0], 1'b1);
    @(posedge pclk);
    u_target.put(16'hab35);
    #1 chkb(terms0[0], 1'b0);
    wr(TTA_INV, 32'h1);
    #1 chkb(terms0[0], 1'b1);
    @(posedge pclk);
    // Bounds are inclusive at both ends
    wr(TTA_RNG, 32'h00200010);
    for (int i = 0; i < 4; i++) begin
      u_target.put(rv[i]);
      #1 chkb(terms0[10], re[i]);
      @(posedge pclk);
    end
    wr(TTA_INV, 32'h400);
    #1 chkb(terms0[10], 1'b1);
    @(posedge pclk);
    // Presets: set loads ones, clear widens pattern and bounds
    wr(TTA_CMD, 32'h21);
    rd(TTA_PAT + 8'h04, 32'hffffffff);
    wr(TTA_CMD, 32'h11);
    rd(TTA_PAT + 8'h04, 32'h0000ffff);
    wr(TTA_CMD, 32'h1a);
    rd(TTA_RNG, 32'hffff0000);
    // Transition term: silent in state mode, ORed channels in timing mode
    wr(TTA_EDGE, 32'h9);
    u_target.put(16'h0008);
    #1 chkb(terms0[12], 1'b0);
    wr(TTA_CTRL, 32'h1);
    u_target.put(16'h0001);
    #1 chkb(terms0[12], 1'b1);
    @(posedge pclk);
    #1 chkb(terms0[12], 1'b0);
    wr(TTA_EDGE, 32'h00080000);
    u_target.put(16'h0009);
    @(posedge pclk);
    u_target.put(16'h0001);
    #1 chkb(terms0[12], 1'b1);
    @(posedge pclk);
    // First level cannot start a timer
    wr(TTA_TPER, 32'd50);
    wr(TTA_TLVL, 32'h1);
    enter(4'h0);
    repeat (70) @(posedge pclk);
    chkb(terms0[14], 1'b0);
    // Start, pause at cycle 10, continue later: expiry only after the rest of the count
    wr(TTA_TLVL + 8'h04, {29'h0, TC_START});
    wr(TTA_TLVL + 8'h08, {29'h0, TC_PAUSE});
    wr(TTA_TLVL + 8'h0c, {29'h0, TC_CONT});
    enter(4'h1);
    repeat (9) @(posedge pclk);
    enter(4'h2);
    repeat (80) @(posedge pclk);
    chkb(terms0[14], 1'b0);
    enter(4'h3);
    wait_tmr();
    chkb(n > 33 && n < 45, 1'b1);
    enter(4'h1);
    wait_tmr();
    chkb(n > 45 && n < 55, 1'b1);
    // Arm term at level 2 from the port, evaluated like any term
    wr(TTA_ARM, 32'h0000020a);
    enter(4'h2);
    #1 chkb(terms0[16], 1'b0);
    @(posedge pclk);
    u_target.pulse_arm();
    repeat (2) @(posedge pclk);
    #1 chkb(terms0[16], 1'b1);
    @(posedge pclk);
    // Both branches true: primary wins
    seq0.prim_hit <= 1'b1;
    seq0.sec_hit <= 1'b1;
    seq1.sec_hit <= 1'b1;
    @(posedge pclk);
    #1 chk({28'h0, take_prim, take_sec}, {28'h0, 2'b01, 2'b10});
    @(posedge pclk);
    // Pattern 0 moves to machine 1; combination as AND, then as inverted OR
    u_target.put(16'h1234);
    wr(TTA_OWNER, 32'h1);
    wr(TTA_COMB1, 32'h1);
    #1 chk({28'h0, comb_hit, terms1[0], terms0[0]}, {28'h0, 4'b1110});
    wr(TTA_COMB1, 32'h00030003);
    #1 chk({28'h0, comb_hit, terms1[0], terms0[0]}, {28'h0, 4'b0110});
    // Run start arms machine 0, its trigger arms machine 1, which drives scope and port
    wr(TTA_ARM, 32'h000200d0);
    seq0.level <= 4'h0;
    run_start <= 1'b1;
    @(posedge pclk);
    run_start <= 1'b0;
    #1 chk({28'h0, scope_arm, arm_out, terms1[16], terms0[16]}, {28'h0, 4'b0001});
    @(posedge pclk);
    seq0.trig <= 1'b1;
    @(posedge pclk);
    seq0.trig <= 1'b0;
    #1 chk({28'h0, scope_arm, arm_out, terms1[16], terms0[16]}, {28'h0, 4'b0011});
    @(posedge pclk);
    seq1.trig <= 1'b1;
    @(posedge pclk);
    seq1.trig <= 1'b0;
    #1 chk({28'h0, scope_arm, arm_out, terms1[16], terms0[16]}, {28'h0, 4'b1111});
    @(posedge pclk);
    #1 chk({28'h0, scope_arm, arm_out, terms1[16], terms0[16]}, {28'h0, 4'b0011});
    // Port out taken from the scope trigger instead
    wr(TTA_ARM, 32'h00000060);
    scope_trig <= 1'b1;
    @(posedge pclk);
    scope_trig <= 1'b0;
    #1 chk({28'h0, scope_arm, arm_out, terms1[16], terms0[16]}, {28'h0, 4'b0111});
    end_sim();
  end
endmodule
`default_nettype wire

/* tb/tta_target_model.sv */
// Target-side model: drives the sampled label value and the external arm pulse
`timescale 1ns/1ps
`default_nettype none
module tta_target_model (
  input wire logic pclk, // Sample clock
  output logic [15:0] sample, // Label value seen by the probes
  output logic arm_in // Arm pulse from an outside instrument
);
  // Quiet target until a scenario asks for activity
  initial begin
    sample = 16'h0000;
    arm_in = 1'b0;
  end
  // New label value, launched just after an edge so it is settled before the next one
  task put(input logic [15:0] v);
    sample <= v;
  endtask
  // Arm pulse lasts exactly one sample, as an outside instrument would send it
  task pulse_arm();
    arm_in <= 1'b1;
    @(posedge pclk);
    arm_in <= 1'b0;
  endtask
endmodule
`default_nettype wire
